// file: fvsr_pkg.sv
// Purpose: shared types and constants of the fault value snapshot recorder
// Assumes: one channel sample per SMP_PERIOD_US, sample strobe on ref_clk_in
// Notes:   all capture offsets are fixed; nothing here is adjustable at run time
package fvsr_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SMP_PERIOD_US = 1000;
  localparam int unsigned NUM_CH        = 3;
  localparam int unsigned SEC_W         = 16;
  localparam int unsigned RAT_W         = 16;
  localparam int unsigned PRI_W         = 32;

  // capture offsets around the start edge, in milliseconds
  localparam int unsigned PRE_MS    = 100;
  localparam int unsigned FLT_A_MS  = 10;
  localparam int unsigned FLT_B_MS  = 20;

  // the same offsets as counts of samples
  localparam int unsigned PRE_SMP   = PRE_MS * 1000 / SMP_PERIOD_US;
  localparam int unsigned FLT_A_SMP = FLT_A_MS * 1000 / SMP_PERIOD_US;
  localparam int unsigned FLT_B_SMP = FLT_B_MS * 1000 / SMP_PERIOD_US;

  // history depth: next power of two above the pre-fault lag
  localparam int unsigned HIST_AW   = $clog2(PRE_SMP + 2);
  localparam int unsigned CNT_W     = $clog2(FLT_B_SMP + 1);

  localparam logic [HIST_AW-1:0] PRE_LAG   = HIST_AW'(PRE_SMP);
  localparam logic [CNT_W-1:0]   FLT_A_CNT = CNT_W'(FLT_A_SMP);
  localparam logic [CNT_W-1:0]   FLT_B_CNT = CNT_W'(FLT_B_SMP);

  typedef enum logic [1:0] {
    FVSR_SRC_CURRENT,
    FVSR_SRC_VOLTAGE,
    FVSR_SRC_SYMMETRICAL,
    FVSR_SRC_DIFF_BIAS
  } fvsr_src_t;

  typedef enum logic {
    FVSR_EVT_PREFAULT,
    FVSR_EVT_FAULT
  } fvsr_evt_kind_t;

  typedef struct packed {
    logic [NUM_CH-1:0][SEC_W-1:0] sec;
    logic [NUM_CH-1:0][RAT_W-1:0] ratio;
  } fvsr_sample_t;

  typedef struct packed {
    fvsr_evt_kind_t               kind;
    fvsr_src_t [NUM_CH-1:0]       src;
    logic [NUM_CH-1:0][PRI_W-1:0] value;
  } fvsr_event_t;

endpackage

// file: fvsr_scale.sv
// Purpose: converts one secondary-side sample to a primary-side value
// Assumes: signed secondary sample, unsigned transformer ratio
// Notes:   one cycle of latency; product is cut to the primary width
module fvsr_scale
  import fvsr_pkg::*;
(
  input  wire logic             ref_clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [SEC_W-1:0] sec_in,
  input  wire logic [RAT_W-1:0] ratio_in,
  output logic      [PRI_W-1:0] pri_out
);

  wire logic signed [SEC_W+RAT_W:0] prod;

  assign prod = $signed(sec_in) * $signed({1'b0, ratio_in});

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pri_out <= '0;
    end else begin
      pri_out <= prod[PRI_W-1:0];
    end
  end

endmodule // fvsr_scale

// file: fvsr_history.sv
// Purpose: circular history of the primary values of all channels
// Assumes: one write per sample strobe
// Notes:   read is registered; lag counts back from the newest stored sample
module fvsr_history
  import fvsr_pkg::*;
(
  input  wire logic                         ref_clk_in,
  input  wire logic                         rst_b_in,
  input  wire logic                         wr_en_in,
  input  wire logic [NUM_CH-1:0][PRI_W-1:0] wr_data_in,
  input  wire logic [HIST_AW-1:0]           lag_in,
  output logic      [NUM_CH-1:0][PRI_W-1:0] rd_data_out
);

  logic [NUM_CH-1:0][PRI_W-1:0] mem [2**HIST_AW];
  logic [HIST_AW-1:0]           wr_ptr_q;
  wire logic [HIST_AW-1:0]      rd_addr;

  assign rd_addr = wr_ptr_q - HIST_AW'(1) - lag_in;

  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem[wr_ptr_q] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wr_ptr_q    <= '0;
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem[rd_addr];
      if (wr_en_in) begin
        wr_ptr_q <= wr_ptr_q + HIST_AW'(1);
      end
    end
  end

endmodule // fvsr_history

// file: fvsr_recorder.sv
// Purpose: captures pre-fault and fault values around a protection pickup
//          and releases them as event records once a trip follows
// Assumes: pickup, trip and samples come from logic on ref_clk_in
// Notes:   history must hold PRE_SMP + 1 samples before a pickup is meaningful

module fvsr_recorder
  import fvsr_pkg::*;
(
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   protection_pickup_input_in,
  input  wire logic                   protection_trip_input_in,
  input  wire logic                   sample_valid_in,
  input  wire fvsr_sample_t           sample_in,
  input  wire fvsr_src_t [NUM_CH-1:0] chan_src_in,
  output fvsr_event_t                 list_event_out,
  output logic                        list_valid_out,
  input  wire logic                   list_ready_in,
  output fvsr_event_t                 scada_event_out,
  output logic                        scada_valid_out,
  input  wire logic                   scada_ready_in
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_COLLECT,
    ST_ARMED,
    ST_EMIT_PRE,
    ST_EMIT_FLT
  } fvsr_state_t;

  fvsr_state_t                  state_q;
  fvsr_state_t                  state_d;

  logic                         pickup_q;
  logic                         pri_valid_q;
  logic                         pre_load_q;
  logic                         trip_pend_q;
  logic [CNT_W-1:0]             cnt_q;
  logic [NUM_CH-1:0][PRI_W-1:0] pre_q;
  logic [NUM_CH-1:0][PRI_W-1:0] flt_a_q;
  logic [NUM_CH-1:0][PRI_W-1:0] flt_q;
  fvsr_src_t [NUM_CH-1:0]       src_q;
  fvsr_event_t                  evt_q;
  logic                         list_done_q;
  logic                         scada_done_q;

  wire logic [NUM_CH-1:0][PRI_W-1:0] pri;
  wire logic [NUM_CH-1:0][PRI_W-1:0] hist_rd;
  wire logic [NUM_CH-1:0][PRI_W-1:0] flt_avg;
  wire logic                         start_rise;
  wire logic                         trip_seen;
  wire logic [CNT_W-1:0]             cnt_inc;
  wire logic                         hit_a;
  wire logic                         hit_b;
  wire logic                         list_ok;
  wire logic                         scada_ok;
  wire logic                         evt_done;
  wire fvsr_event_t                  pre_rec;
  wire fvsr_event_t                  flt_rec;

  // secondary-to-primary conversion, one scaler per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_scale
    fvsr_scale u_scale (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .sec_in     (sample_in.sec[c]),
      .ratio_in   (sample_in.ratio[c]),
      .pri_out    (pri[c])
    );
  end

  // history of primary values, read at a fixed lag
  fvsr_history u_hist (
    .ref_clk_in  (ref_clk_in),
    .rst_b_in    (rst_b_in),
    .wr_en_in    (pri_valid_q),
    .wr_data_in  (pri),
    .lag_in      (PRE_LAG),
    .rd_data_out (hist_rd)
  );

  // mean of the two fault samples, widened by one bit so the sum cannot wrap
  for (genvar c = 0; c < NUM_CH; c++) begin : g_avg
    wire logic [PRI_W:0] sum;
    assign sum        = {flt_a_q[c][PRI_W-1], flt_a_q[c]} + {pri[c][PRI_W-1], pri[c]};
    assign flt_avg[c] = sum[PRI_W:1];
  end

  // edge of the pickup input; the trip input is taken as a level
  assign start_rise = protection_pickup_input_in & ~pickup_q;
  assign trip_seen  = protection_trip_input_in;

  // sample counter since the pickup edge
  assign cnt_inc = cnt_q + CNT_W'(1);
  assign hit_a   = pri_valid_q && (cnt_inc == FLT_A_CNT);
  assign hit_b   = pri_valid_q && (cnt_inc == FLT_B_CNT);

  // a record completes once both destinations have taken it
  assign list_ok  = list_done_q | (list_valid_out & list_ready_in);
  assign scada_ok = scada_done_q | (scada_valid_out & scada_ready_in);
  assign evt_done = list_ok & scada_ok;

  assign pre_rec = '{kind: FVSR_EVT_PREFAULT, src: src_q, value: pre_q};
  assign flt_rec = '{kind: FVSR_EVT_FAULT, src: src_q, value: flt_q};

  // both destinations see the same registered record
  assign list_event_out  = evt_q;
  assign scada_event_out = evt_q;
  // a record is on offer in both emit states
  wire logic emitting;
  assign emitting        = (state_q == ST_EMIT_PRE) || (state_q == ST_EMIT_FLT);
  assign list_valid_out  = emitting && !list_done_q;
  assign scada_valid_out = emitting && !scada_done_q;

  // sequence control
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_rise) begin
          state_d = ST_COLLECT;
        end
      end
      ST_COLLECT: begin
        if (start_rise) begin
          state_d = ST_COLLECT;
        end else if (hit_b) begin
          state_d = (trip_pend_q || trip_seen) ? ST_EMIT_PRE : ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (start_rise) begin
          state_d = ST_COLLECT;
        end else if (trip_seen) begin
          state_d = ST_EMIT_PRE;
        end
      end
      ST_EMIT_PRE: begin
        if (evt_done) begin
          state_d = ST_EMIT_FLT;
        end
      end
      ST_EMIT_FLT: begin
        if (evt_done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // previous pickup level for the edge detector; strobe aligned with the scalers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pickup_q    <= 1'b0;
      pri_valid_q <= 1'b0;
    end else begin
      pickup_q    <= protection_pickup_input_in;
      pri_valid_q <= sample_valid_in;
    end
  end

  // pickup edges are ignored while a record set is being emitted
  wire logic capture_start;
  wire logic in_collect;
  wire logic collect_step;
  assign capture_start = start_rise && !emitting;
  assign in_collect    = (state_q == ST_COLLECT);
  assign collect_step  = in_collect && !start_rise;

  // sample counter since the pickup edge
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in || capture_start) begin
      cnt_q <= '0;
    end else if (in_collect && pri_valid_q) begin
      cnt_q <= cnt_inc;
    end
  end

  // trip latch: a new pickup drops an older trip, a trip in the same cycle still counts
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      trip_pend_q <= 1'b0;
    end else if (capture_start) begin
      trip_pend_q <= trip_seen;
    end else if (in_collect) begin
      if (trip_seen) begin
        trip_pend_q <= 1'b1;
      end
    end else begin
      trip_pend_q <= 1'b0;
    end
  end

  // channel quantity kinds travel with the records
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      src_q <= '{default: FVSR_SRC_CURRENT};
    end else if (capture_start) begin
      src_q <= chan_src_in;
    end
  end

  // pre-fault capture: history read lands one cycle after the edge
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pre_load_q <= 1'b0;
      pre_q      <= '0;
    end else begin
      pre_load_q <= capture_start;
      if (pre_load_q) begin
        pre_q <= hist_rd;
      end
    end
  end

  // fault capture: first sample held, second averaged in
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      flt_a_q <= '0;
    end else if (collect_step && hit_a) begin
      flt_a_q <= pri;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      flt_q <= '0;
    end else if (collect_step && hit_b) begin
      flt_q <= flt_avg;
    end
  end

  // record load points; acceptance flags restart with every new record
  wire logic load_pre;
  wire logic load_flt;
  wire logic clr_done;
  assign load_pre = (state_q != ST_EMIT_PRE) && (state_d == ST_EMIT_PRE);
  assign load_flt = (state_q == ST_EMIT_PRE) && evt_done;
  assign clr_done = load_pre || evt_done;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      evt_q <= '0;
    end else if (load_pre) begin
      evt_q <= pre_rec;
    end else if (load_flt) begin
      evt_q <= flt_rec;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in || clr_done) begin
      list_done_q  <= 1'b0;
      scada_done_q <= 1'b0;
    end else begin
      list_done_q  <= list_ok;
      scada_done_q <= scada_ok;
    end
  end

  // fixed offsets, no settings port and no binary outputs by construction

endmodule // fvsr_recorder

// file: fvsr_chk.sv
// Purpose: port checks of the snapshot recorder
// Assumes: one clock, sync active-low reset
// Notes:   bound into fvsr_recorder below
module fvsr_chk
  import fvsr_pkg::*;
(
  input wire logic                   ref_clk_in,
  input wire logic                   rst_b_in,
  input wire logic                   protection_pickup_input_in,
  input wire logic                   protection_trip_input_in,
  input wire logic                   sample_valid_in,
  input wire fvsr_sample_t           sample_in,
  input wire fvsr_src_t [NUM_CH-1:0] chan_src_in,
  input wire fvsr_event_t            list_event_out,
  input wire logic                   list_valid_out,
  input wire logic                   list_ready_in,
  input wire fvsr_event_t            scada_event_out,
  input wire logic                   scada_valid_out,
  input wire logic                   scada_ready_in
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire  any_v = list_valid_out | scada_valid_out;
  logic tseen_q;
  // a trip seen since the last pickup edge or emission
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) tseen_q <= 1'b0;
    else if (protection_trip_input_in) tseen_q <= 1'b1;
    else if ($fell(any_v) || $rose(protection_pickup_input_in)) tseen_q <= 1'b0;
  end
  sequence s_quiet8; !any_v [*8]; endsequence
  sequence s_list_wait; list_valid_out && !list_ready_in; endsequence
  sequence s_scada_wait; scada_valid_out && !scada_ready_in; endsequence
  a_reset_quiet: assert property ($rose(rst_b_in) |-> !any_v && list_event_out == '0)
    else $error("output active after reset");
  a_list_hold: assert property (s_list_wait |=> list_valid_out && $stable(list_event_out))
    else $error("list record dropped");
  a_scada_hold: assert property (s_scada_wait |=> scada_valid_out && $stable(scada_event_out))
    else $error("scada record dropped");
  a_same_record: assert property (list_event_out == scada_event_out)
    else $error("destinations differ");
  a_first_prefault: assert property ($rose(any_v) |-> list_event_out.kind == FVSR_EVT_PREFAULT)
    else $error("first record not prefault");
  a_last_fault: assert property ($fell(any_v) |-> $past(list_event_out.kind) == FVSR_EVT_FAULT)
    else $error("last record not fault");
  a_emit_trip: assert property ($rose(any_v) |-> tseen_q)
    else $error("records without trip");
  a_pickup_quiet: assert property ($rose(protection_pickup_input_in) && !any_v
    && !protection_trip_input_in |=> s_quiet8)
    else $error("records too soon after pickup");
  a_drop_ready: assert property ($fell(list_valid_out) |-> $past(list_ready_in))
    else $error("list valid fell without ready");
endmodule // fvsr_chk
bind fvsr_recorder fvsr_chk u_fvsr_chk (.ref_clk_in, .rst_b_in, .protection_pickup_input_in,
  .protection_trip_input_in, .sample_valid_in, .sample_in, .chan_src_in, .list_event_out,
  .list_valid_out, .list_ready_in, .scada_event_out, .scada_valid_out, .scada_ready_in);

// file: fvsr_prot_model.sv
// Purpose: protection pickup and trip logic beside the recorder
// Assumes: levels change just after a rising edge
// Notes:   driven by the bench through its tasks
module fvsr_prot_model (
  input  wire logic ref_clk_in,
  output logic      pickup_out,
  output logic      trip_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pickup_out = 1'b0;
    trip_out   = 1'b0;
  end
  task automatic pickup_set(input logic v);
    @(posedge ref_clk_in);
    pickup_out <= v;
  endtask
  task automatic trip_set(input logic v);
    @(posedge ref_clk_in);
    trip_out <= v;
  endtask
endmodule // fvsr_prot_model

// file: tb.sv
// Purpose: self-checking bench of the snapshot recorder
// Assumes: one sample strobe every 8 clocks
// Notes:   queue model of history, compared per record
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fvsr_pkg::*;
  logic                         ref_clk_in, rst_b_in, sample_valid_in, pickup, trip;
  logic                         list_ready_in, scada_ready_in, list_v, scada_v;
  fvsr_sample_t                 sample_in;
  fvsr_src_t [NUM_CH-1:0]       chan_src_in, pk_src;
  fvsr_event_t                  list_ev, scada_ev, exp_q[$], got_l[$], got_s[$];
  logic [NUM_CH-1:0][PRI_W-1:0] hist[$];
  logic                         pk_prev = 1'b0;
  int error_cnt = 0, n_checks = 0, seed = 87528, cnt = 0, base = 0, stall = 0, k = 0;
  fvsr_recorder u_fvsr_recorder (.ref_clk_in, .rst_b_in, .protection_pickup_input_in(pickup),
    .protection_trip_input_in(trip), .sample_valid_in, .sample_in, .chan_src_in,
    .list_event_out(list_ev), .list_valid_out(list_v), .list_ready_in,
    .scada_event_out(scada_ev), .scada_valid_out(scada_v), .scada_ready_in);
  fvsr_prot_model u_fvsr_prot_model (.ref_clk_in, .pickup_out(pickup), .trip_out(trip));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  function automatic logic [PRI_W-1:0] prim(logic [SEC_W-1:0] s, logic [RAT_W-1:0] r);
    return PRI_W'(longint'($signed(s)) * longint'(r));
  endfunction
  always @(posedge ref_clk_in) begin
    cnt <= cnt + 1;
    sample_valid_in <= (cnt % 8 == 0);
    sample_in <= {$random(seed), $random(seed), $random(seed)} & {48'hffff_ffff_ffff, 48'h00ff_00ff_00ff};
    list_ready_in <= stall == 0 || $random(seed) % 2 == 0;
    scada_ready_in <= stall == 0 || $random(seed) % 2 == 0;
    if (pickup && !pk_prev) begin
      base <= hist.size();
      pk_src <= chan_src_in;
    end
    pk_prev <= pickup;
    if (sample_valid_in && rst_b_in) hist.push_back({prim(sample_in.sec[2], sample_in.ratio[2]),
      prim(sample_in.sec[1], sample_in.ratio[1]), prim(sample_in.sec[0], sample_in.ratio[0])});
    if (list_v && list_ready_in) got_l.push_back(list_ev);
    if (scada_v && scada_ready_in) got_s.push_back(scada_ev);
  end
  task automatic cmp_evt(input fvsr_event_t got, input fvsr_event_t exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_n(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic expect_pair();
    fvsr_event_t e;
    longint      a;
    e.src = pk_src;
    e.kind = FVSR_EVT_PREFAULT;
    for (int c = 0; c < NUM_CH; c++) e.value[c] = hist[base-101][c];
    exp_q.push_back(e);
    e.kind = FVSR_EVT_FAULT;
    for (int c = 0; c < NUM_CH; c++) begin
      a = longint'($signed(hist[base+9][c])) + longint'($signed(hist[base+19][c]));
      e.value[c] = PRI_W'(a >>> 1);
    end
    exp_q.push_back(e);
  endtask
  // n_pk pickups, then trip trip_smp samples after the last one
  task automatic fault(input int n_pk, input int trip_smp, input string name);
    int t;
    t = 0;
    repeat (n_pk) begin
      while (cnt % 8 != 3) @(posedge ref_clk_in);
      for (int c = 0; c < NUM_CH; c++) chan_src_in[c] <= fvsr_src_t'(2'(k + c));
      u_fvsr_prot_model.pickup_set(1'b1);
      repeat (40) @(posedge ref_clk_in);
      u_fvsr_prot_model.pickup_set(1'b0);
    end
    repeat (8 * trip_smp - 40) @(posedge ref_clk_in);
    u_fvsr_prot_model.trip_set(1'b1);
    while ((got_l.size() < 2 || got_s.size() < 2) && t < 3000) begin
      @(posedge ref_clk_in);
      t++;
    end
    expect_pair();
    for (int i = 0; i < 2; i++) begin
      cmp_evt(got_l[i], exp_q[i]);
      cmp_evt(got_s[i], exp_q[i]);
    end
    u_fvsr_prot_model.trip_set(1'b0);
    repeat (30) @(posedge ref_clk_in);
    cmp_n(got_l.size() + got_s.size(), 4);
    got_l.delete();
    got_s.delete();
    exp_q.delete();
    k++;
    $display("test %s done", name);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst_b_in = 1'b0;
    chan_src_in = '0;
    repeat (3) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    repeat (900) @(posedge ref_clk_in);
    fault(1, 25, "armed");
    fault(2, 25, "repickup");
    fault(1, 6, "early trip");
    stall = 1;
    fault(1, 25, "stalled");
    stall = 0;
    u_fvsr_prot_model.trip_set(1'b1);
    repeat (50) @(posedge ref_clk_in);
    u_fvsr_prot_model.trip_set(1'b0);
    cmp_n(got_l.size() + got_s.size(), 0);
    $display("test idle trip done");
    final_report();
  end
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
endmodule // tb
